// ---- isfb_flag_bank.v ----
/*
 * isfb_flag_bank.v - interrupt request flags, enables and related control
 * bits for an 8-bit controller, reached as special function registers.
 * Assumes the core gives single-cycle write/read strobes on the sfr bus,
 * a one-cycle vector acknowledge, and that peripheral events arrive as
 * one-cycle pulses on sys_clk_in; external pins are asynchronous.
 */
// What this block does
// - timer1 overflow sets flag; vector or software clears
// - timer0 overflow sets flag; vector or software clears
// - run bits enable their timers
// - ext1 flag set on selected edge, auto-cleared
// - ext1 select 0 both edges, 1 falling
// - ext0 flag set on selected edge, auto-cleared
// - ext0 select 0 both edges, 1 falling
// - uart1 transmit flag set by hardware, software clears
// - uart1 receive flag set at stop sample
// - uart2 flags in bits one and zero
// - uart3 flags like uart1, own vector
// - uart4 flags like uart1, own vector
// - baud double bit doubles uart rate
// - frame error select picks bit seven view
// - low supply flag sticky until software clear
// - power-on flag cleared only by software
// - global gate off blocks all requests
// - low supply and converter enables gate
// - converter power bit powers converter
// - converter done flag, sticky, is request
// - start bit begins conversion, self-clears
// - each enable bit gates its interrupt
// - fixed polling order within a level
`timescale 1ns/1ps
`default_nettype none
`include "isfb_defs.vh"

module isfb_flag_bank (
	// clock and reset
	input wire sys_clk_in,
	input wire nrst_in,
	// sfr bus from the core
	input wire [7:0] sfr_addr_in,
	input wire [7:0] sfr_wdata_in,
	input wire sfr_wr_in,
	input wire sfr_rd_in,
	output reg [7:0] sfr_rdata_out,
	// peripheral event pulses
	input wire timer1_overflow_in,
	input wire timer0_overflow_in,
	input wire [3:0] uart_tx_done_in,
	input wire [3:0] uart_rx_done_in,
	input wire frame_error_in,
	input wire low_supply_in,
	input wire power_on_event_in,
	input wire conv_done_in,
	// external interrupt pins, asynchronous
	input wire ext_pin_a_in,
	input wire ext_pin_b_in,
	// core vector request and acknowledge
	input wire vec_ack_in,
	input wire [4:0] vec_ack_code_in,
	output reg irq_req_out,
	output reg [4:0] irq_vec_out,
	// control outputs to peripherals
	output reg timer1_run_out,
	output reg timer0_run_out,
	output reg baud_double_out,
	output reg conv_power_out,
	output reg conv_start_out
);

	// ==========================================================
	// register state
	reg [7:0] tmr_ext_q;
	reg [7:0] pwr_q;
	reg [7:0] ien_q;
	reg [7:0] ien_aux_q;
	reg [7:0] conv_q;
	reg [7:0] uart_ctrl_q [0:3];
	reg frame_error_flag_q;
	reg [1:0] pin_a_sync_q;
	reg [1:0] pin_b_sync_q;
	reg pin_a_prev_q;
	reg pin_b_prev_q;
	reg [`ISFB_NVEC-1:0] req_d;
	reg [4:0] vec_d;
	reg [7:0] rdata_d;
	integer k;

	// ==========================================================
	// decode helpers
	function wr_hit;
		input [7:0] addr;
		begin
			wr_hit = sfr_wr_in && (sfr_addr_in == addr);
		end
	endfunction

	function ack_hit;
		input [4:0] code;
		begin
			ack_hit = vec_ack_in && (vec_ack_code_in == code);
		end
	endfunction

	// edge select: 0 means both edges, 1 means falling only
	function edge_event;
		input sel;
		input cur;
		input prev;
		begin
			edge_event = sel ? (prev & ~cur) : (prev ^ cur);
		end
	endfunction

	// next state of a sticky flag; the set term is applied last so a
	// same-cycle event always wins over the clear
	function flag_next;
		input cur;
		input do_wr;
		input wr_val;
		input hw_clr;
		input hw_set;
		begin
			flag_next = cur;
			if (hw_clr) begin
				flag_next = 1'b0;
			end
			if (do_wr) begin
				flag_next = wr_val;
			end
			if (hw_set) begin
				flag_next = 1'b1;
			end
		end
	endfunction

	// ==========================================================
	// pin synchronisers and edge detect
	wire ext_pin_a;
	wire ext_pin_b;
	assign ext_pin_a = pin_a_sync_q[1];
	assign ext_pin_b = pin_b_sync_q[1];
	wire ext1_edge;
	wire ext0_edge;
	assign ext1_edge = edge_event(tmr_ext_q[`ISFB_X1_SEL], ext_pin_a, pin_a_prev_q);
	assign ext0_edge = edge_event(tmr_ext_q[`ISFB_X0_SEL], ext_pin_b, pin_b_prev_q);

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_a_sync_q <= `ISFB_SYNC_IDLE;
			pin_b_sync_q <= `ISFB_SYNC_IDLE;
			pin_a_prev_q <= 1'b1;
			pin_b_prev_q <= 1'b1;
		end else begin
			pin_a_sync_q <= {pin_a_sync_q[0], ext_pin_a_in};
			pin_b_sync_q <= {pin_b_sync_q[0], ext_pin_b_in};
			pin_a_prev_q <= ext_pin_a;
			pin_b_prev_q <= ext_pin_b;
		end
	end

	// ==========================================================
	// timer and external interrupt control
	wire tx_wr;
	assign tx_wr = wr_hit(`ISFB_ADDR_TMR_EXT_CTRL);

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tmr_ext_q <= `ISFB_RST_BYTE;
		end else begin
			tmr_ext_q[`ISFB_T1_OVF] <= flag_next(tmr_ext_q[`ISFB_T1_OVF], tx_wr,
				sfr_wdata_in[`ISFB_T1_OVF], ack_hit(`ISFB_CODE_T1),
				timer1_overflow_in);
			tmr_ext_q[`ISFB_T0_OVF] <= flag_next(tmr_ext_q[`ISFB_T0_OVF], tx_wr,
				sfr_wdata_in[`ISFB_T0_OVF], ack_hit(`ISFB_CODE_T0),
				timer0_overflow_in);
			tmr_ext_q[`ISFB_X1_REQ] <= flag_next(tmr_ext_q[`ISFB_X1_REQ], tx_wr,
				sfr_wdata_in[`ISFB_X1_REQ], ack_hit(`ISFB_CODE_X1), ext1_edge);
			tmr_ext_q[`ISFB_X0_REQ] <= flag_next(tmr_ext_q[`ISFB_X0_REQ], tx_wr,
				sfr_wdata_in[`ISFB_X0_REQ], ack_hit(`ISFB_CODE_X0), ext0_edge);
			if (tx_wr) begin
				tmr_ext_q[`ISFB_T1_RUN] <= sfr_wdata_in[`ISFB_T1_RUN];
				tmr_ext_q[`ISFB_T0_RUN] <= sfr_wdata_in[`ISFB_T0_RUN];
				tmr_ext_q[`ISFB_X1_SEL] <= sfr_wdata_in[`ISFB_X1_SEL];
				tmr_ext_q[`ISFB_X0_SEL] <= sfr_wdata_in[`ISFB_X0_SEL];
			end
		end
	end

	// ==========================================================
	// four uart control registers; the flag bits and bits seven to two
	// all live here, with bits seven to two stored as written
	wire [7:0] uart_addr [0:3];
	assign uart_addr[0] = `ISFB_ADDR_UART1_CTRL;
	assign uart_addr[1] = `ISFB_ADDR_UART2_CTRL;
	assign uart_addr[2] = `ISFB_ADDR_UART3_CTRL;
	assign uart_addr[3] = `ISFB_ADDR_UART4_CTRL;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_uart
			wire u_wr;
			assign u_wr = wr_hit(uart_addr[g]);
			always @(posedge sys_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					uart_ctrl_q[g] <= `ISFB_RST_BYTE;
				end else begin
					// flags never clear on acknowledge, only by write
					uart_ctrl_q[g][`ISFB_U_TX] <= flag_next(uart_ctrl_q[g][`ISFB_U_TX],
						u_wr, sfr_wdata_in[`ISFB_U_TX], 1'b0, uart_tx_done_in[g]);
					uart_ctrl_q[g][`ISFB_U_RX] <= flag_next(uart_ctrl_q[g][`ISFB_U_RX],
						u_wr, sfr_wdata_in[`ISFB_U_RX], 1'b0, uart_rx_done_in[g]);
					if (u_wr) begin
						uart_ctrl_q[g][`ISFB_U_STORE] <= sfr_wdata_in[`ISFB_U_STORE];
					end
				end
			end
		end
	endgenerate

	// frame error is set regardless of the select bit
	wire u1_wr;
	assign u1_wr = wr_hit(`ISFB_ADDR_UART1_CTRL);
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frame_error_flag_q <= 1'b0;
		end else begin
			frame_error_flag_q <= flag_next(frame_error_flag_q,
				u1_wr && pwr_q[`ISFB_P_FESEL], sfr_wdata_in[`ISFB_U_HI],
				1'b0, frame_error_in);
		end
	end

	// ==========================================================
	// power control, enables and converter control
	wire p_wr;
	wire c_wr;
	assign p_wr = wr_hit(`ISFB_ADDR_PWR_CTRL);
	assign c_wr = wr_hit(`ISFB_ADDR_CONV_CTRL);

	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pwr_q <= `ISFB_RST_PWR;
			ien_q <= `ISFB_RST_BYTE;
			ien_aux_q <= `ISFB_RST_BYTE;
			conv_q <= `ISFB_RST_BYTE;
		end else begin
			if (p_wr) begin
				pwr_q[`ISFB_P_BAUD2] <= sfr_wdata_in[`ISFB_P_BAUD2];
				pwr_q[`ISFB_P_FESEL] <= sfr_wdata_in[`ISFB_P_FESEL];
				pwr_q[`ISFB_P_GEN] <= sfr_wdata_in[`ISFB_P_GEN];
			end
			pwr_q[`ISFB_P_LOWV] <= flag_next(pwr_q[`ISFB_P_LOWV], p_wr,
				sfr_wdata_in[`ISFB_P_LOWV], 1'b0, low_supply_in);
			pwr_q[`ISFB_P_PON] <= flag_next(pwr_q[`ISFB_P_PON], p_wr,
				sfr_wdata_in[`ISFB_P_PON], 1'b0, power_on_event_in);
			if (wr_hit(`ISFB_ADDR_IRQ_EN_MAIN)) begin
				ien_q <= sfr_wdata_in;
			end
			if (wr_hit(`ISFB_ADDR_IRQ_EN_AUX)) begin
				ien_aux_q <= sfr_wdata_in;
			end
			if (c_wr) begin
				conv_q[`ISFB_C_PWR] <= sfr_wdata_in[`ISFB_C_PWR];
				conv_q[`ISFB_C_SPEED] <= sfr_wdata_in[`ISFB_C_SPEED];
				conv_q[`ISFB_C_CHAN] <= sfr_wdata_in[`ISFB_C_CHAN];
			end
			conv_q[`ISFB_C_DONE] <= flag_next(conv_q[`ISFB_C_DONE], c_wr,
				sfr_wdata_in[`ISFB_C_DONE], 1'b0, conv_done_in);
			// finishing a conversion wins over a write of the start bit
			if (conv_done_in) begin
				conv_q[`ISFB_C_START] <= 1'b0;
			end else if (c_wr) begin
				conv_q[`ISFB_C_START] <= sfr_wdata_in[`ISFB_C_START];
			end
		end
	end

	// ==========================================================
	// request gating and fixed polling order
	wire gate;
	assign gate = ien_q[`ISFB_E_ALL];

	always @* begin
		req_d = {`ISFB_NVEC{1'b0}};
		if (gate) begin
			req_d[`ISFB_VEC_X0] = tmr_ext_q[`ISFB_X0_REQ] & ien_q[`ISFB_E_X0];
			req_d[`ISFB_VEC_T0] = tmr_ext_q[`ISFB_T0_OVF] & ien_q[`ISFB_E_T0];
			req_d[`ISFB_VEC_X1] = tmr_ext_q[`ISFB_X1_REQ] & ien_q[`ISFB_E_X1];
			req_d[`ISFB_VEC_T1] = tmr_ext_q[`ISFB_T1_OVF] & ien_q[`ISFB_E_T1];
			req_d[`ISFB_VEC_U1] = (|uart_ctrl_q[0][`ISFB_U_FLAGS]) & ien_q[`ISFB_E_U1];
			req_d[`ISFB_VEC_CONV] = conv_q[`ISFB_C_DONE] & ien_q[`ISFB_E_CONV];
			req_d[`ISFB_VEC_LOWV] = pwr_q[`ISFB_P_LOWV] & ien_q[`ISFB_E_LOWV];
			req_d[`ISFB_VEC_U2] = (|uart_ctrl_q[1][`ISFB_U_FLAGS]) & ien_aux_q[`ISFB_A_U2];
			req_d[`ISFB_VEC_U3] = (|uart_ctrl_q[2][`ISFB_U_FLAGS]) &
				ien_aux_q[`ISFB_A_U3];
			req_d[`ISFB_VEC_U4] = (|uart_ctrl_q[3][`ISFB_U_FLAGS]) &
				ien_aux_q[`ISFB_A_U4];
		end
	end

	// lowest index wins: the loop runs from lowest to highest priority
	wire [4:0] vec_code [0:`ISFB_NVEC-1];
	assign vec_code[`ISFB_VEC_X0] = `ISFB_CODE_X0;
	assign vec_code[`ISFB_VEC_T0] = `ISFB_CODE_T0;
	assign vec_code[`ISFB_VEC_X1] = `ISFB_CODE_X1;
	assign vec_code[`ISFB_VEC_T1] = `ISFB_CODE_T1;
	assign vec_code[`ISFB_VEC_U1] = `ISFB_CODE_U1;
	assign vec_code[`ISFB_VEC_CONV] = `ISFB_CODE_CONV;
	assign vec_code[`ISFB_VEC_LOWV] = `ISFB_CODE_LOWV;
	assign vec_code[`ISFB_VEC_U2] = `ISFB_CODE_U2;
	assign vec_code[`ISFB_VEC_U3] = `ISFB_CODE_U3;
	assign vec_code[`ISFB_VEC_U4] = `ISFB_CODE_U4;

	always @* begin
		vec_d = `ISFB_VEC_NONE;
		for (k = `ISFB_NVEC - 1; k >= 0; k = k - 1) begin
			if (req_d[k]) begin
				vec_d = vec_code[k];
			end
		end
	end

	// ==========================================================
	// read mux
	always @* begin
		rdata_d = `ISFB_RST_BYTE;
		case (sfr_addr_in)
			`ISFB_ADDR_TMR_EXT_CTRL: begin
				rdata_d = tmr_ext_q;
			end
			`ISFB_ADDR_UART1_CTRL: begin
				rdata_d = uart_ctrl_q[0];
				if (pwr_q[`ISFB_P_FESEL]) begin
					rdata_d[`ISFB_U_HI] = frame_error_flag_q;
				end
			end
			`ISFB_ADDR_UART2_CTRL: begin
				rdata_d = uart_ctrl_q[1];
			end
			`ISFB_ADDR_UART3_CTRL: begin
				rdata_d = uart_ctrl_q[2];
			end
			`ISFB_ADDR_UART4_CTRL: begin
				rdata_d = uart_ctrl_q[3];
			end
			`ISFB_ADDR_PWR_CTRL: begin
				rdata_d = pwr_q;
			end
			`ISFB_ADDR_IRQ_EN_MAIN: begin
				rdata_d = ien_q;
			end
			`ISFB_ADDR_IRQ_EN_AUX: begin
				rdata_d = ien_aux_q;
			end
			`ISFB_ADDR_CONV_CTRL: begin
				rdata_d = conv_q;
			end
			default: begin
				rdata_d = `ISFB_RST_BYTE;
			end
		endcase
	end

	// ==========================================================
	// registered outputs; request lags its flag by one cycle
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sfr_rdata_out <= `ISFB_RST_BYTE;
			irq_req_out <= 1'b0;
			irq_vec_out <= `ISFB_VEC_NONE;
			timer1_run_out <= 1'b0;
			timer0_run_out <= 1'b0;
			baud_double_out <= 1'b0;
			conv_power_out <= 1'b0;
			conv_start_out <= 1'b0;
		end else begin
			if (sfr_rd_in) begin
				sfr_rdata_out <= rdata_d;
			end
			irq_req_out <= |req_d;
			irq_vec_out <= vec_d;
			timer1_run_out <= tmr_ext_q[`ISFB_T1_RUN];
			timer0_run_out <= tmr_ext_q[`ISFB_T0_RUN];
			baud_double_out <= pwr_q[`ISFB_P_BAUD2];
			conv_power_out <= conv_q[`ISFB_C_PWR];
			conv_start_out <= conv_q[`ISFB_C_START];
		end
	end

endmodule // isfb_flag_bank
`default_nettype wire

// ---- isfb_defs.vh ----
/*
 * isfb_defs.vh - constants for the interrupt source flag bank:
 * register addresses, bit positions, reset values and vector numbers.
 * Assumes it is included by bare name from the flag bank module.
 */
`ifndef ISFB_DEFS_VH
`define ISFB_DEFS_VH

// ==========================================================
// register addresses (8-bit special function space)
`define ISFB_ADDR_UART4_CTRL 8'h84
`define ISFB_ADDR_PWR_CTRL 8'h87
`define ISFB_ADDR_TMR_EXT_CTRL 8'h88
`define ISFB_ADDR_UART1_CTRL 8'h98
`define ISFB_ADDR_UART2_CTRL 8'h9a
`define ISFB_ADDR_IRQ_EN_MAIN 8'ha8
`define ISFB_ADDR_UART3_CTRL 8'hac
`define ISFB_ADDR_CONV_CTRL 8'hbc
`define ISFB_ADDR_IRQ_EN_AUX 8'haf

// ==========================================================
// timer / external interrupt control bits
`define ISFB_T1_OVF 7
`define ISFB_T1_RUN 6
`define ISFB_T0_OVF 5
`define ISFB_T0_RUN 4
`define ISFB_X1_REQ 3
`define ISFB_X1_SEL 2
`define ISFB_X0_REQ 1
`define ISFB_X0_SEL 0

// uart control bits
`define ISFB_U_HI 7
`define ISFB_U_TX 1
`define ISFB_U_RX 0
`define ISFB_U_STORE 7:2
`define ISFB_U_FLAGS 1:0

// power control bits
`define ISFB_P_BAUD2 7
`define ISFB_P_FESEL 6
`define ISFB_P_LOWV 5
`define ISFB_P_PON 4
`define ISFB_P_GEN 3:0

// converter control bits
`define ISFB_C_PWR 7
`define ISFB_C_DONE 4
`define ISFB_C_START 3
`define ISFB_C_SPEED 6:5
`define ISFB_C_CHAN 2:0

// main enable bits
`define ISFB_E_ALL 7
`define ISFB_E_LOWV 6
`define ISFB_E_CONV 5
`define ISFB_E_U1 4
`define ISFB_E_T1 3
`define ISFB_E_X1 2
`define ISFB_E_T0 1
`define ISFB_E_X0 0

// aux enable bits
`define ISFB_A_U4 4
`define ISFB_A_U3 3
`define ISFB_A_U2 0

// ==========================================================
// reset values
`define ISFB_RST_BYTE 8'h00
`define ISFB_RST_PWR 8'h30
`define ISFB_SYNC_IDLE 2'b11

// ==========================================================
// vector numbers, one per request line
`define ISFB_VEC_X0 0
`define ISFB_VEC_T0 1
`define ISFB_VEC_X1 2
`define ISFB_VEC_T1 3
`define ISFB_VEC_U1 4
`define ISFB_VEC_CONV 5
`define ISFB_VEC_LOWV 6
`define ISFB_VEC_U2 7
`define ISFB_VEC_U3 8
`define ISFB_VEC_U4 9
`define ISFB_NVEC 10
`define ISFB_VEC_NONE 5'h1f

// polling-order vector codes seen by the core
`define ISFB_CODE_X0 5'h00
`define ISFB_CODE_T0 5'h01
`define ISFB_CODE_X1 5'h02
`define ISFB_CODE_T1 5'h03
`define ISFB_CODE_U1 5'h04
`define ISFB_CODE_CONV 5'h05
`define ISFB_CODE_LOWV 5'h06
`define ISFB_CODE_U2 5'h08
`define ISFB_CODE_U3 5'h11
`define ISFB_CODE_U4 5'h12

`endif

// ---- isfb_core_model.sv ----
/* behavioural core model: takes vector requests from the flag bank and
   acknowledges each one after a chosen latency, with the code it saw.
   assumes one clock shared with the flag bank. */
`timescale 1ns/1ps
`default_nettype none
module isfb_core_model (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// request from the flag bank
	input wire logic irq_req_in,
	input wire logic [4:0] irq_vec_in,
	// test control
	input wire logic ack_on_in,
	input wire logic [2:0] lat_in,
	// acknowledge to the flag bank
	output logic vec_ack_out,
	output logic [4:0] vec_ack_code_out
);
	logic [2:0] wait_q;
	// ====
	// one acknowledge per request episode unless lat_in is 7; the code toggles when unused
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_q <= 3'h0;
			vec_ack_out <= 1'h0;
			vec_ack_code_out <= 5'h00;
		end else begin
			vec_ack_out <= 1'h0;
			vec_ack_code_out <= ~vec_ack_code_out;
			if (!ack_on_in || !irq_req_in) begin
				wait_q <= 3'h0;
			end else if (wait_q == lat_in) begin
				vec_ack_out <= 1'h1;
				vec_ack_code_out <= irq_vec_in;
				wait_q <= 3'h7;
			end else if (wait_q != 3'h7) begin
				wait_q <= wait_q + 3'h1;
			end
		end
	end
endmodule // isfb_core_model
`default_nettype wire

// ---- isfb_flag_bank_assertions.sv ----
/* checker for the flag bank: timing of requests, acknowledge clears and
   control outputs. assumes it is bound to the flag bank's ports. */
`timescale 1ns/1ps
`default_nettype none
module isfb_flag_bank_assertions (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// register bus
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	// events and vectors
	input wire logic timer0_overflow_in,
	input wire logic conv_done_in,
	input wire logic vec_ack_in,
	input wire logic [4:0] vec_ack_code_in,
	input wire logic irq_req_out,
	input wire logic [4:0] irq_vec_out,
	// control outputs
	input wire logic timer1_run_out,
	input wire logic timer0_run_out,
	input wire logic baud_double_out,
	input wire logic conv_power_out,
	input wire logic conv_start_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	logic [7:0] en_q;
	logic w87, w88, wbc;
	// ====
	// shadow of the main enable register, built from bus writes alone
	assign w87 = sfr_wr_in && sfr_addr_in == 8'h87;
	assign w88 = sfr_wr_in && sfr_addr_in == 8'h88;
	assign wbc = sfr_wr_in && sfr_addr_in == 8'hbc;
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			en_q <= 8'h00;
		end else if (sfr_wr_in && sfr_addr_in == 8'ha8) begin
			en_q <= sfr_wdata_in;
		end
	end
	// ====
	sequence s_t0_ev;
		timer0_overflow_in && en_q[7] && en_q[1] && !vec_ack_in;
	endsequence
	sequence s_t0_ack;
		vec_ack_in && vec_ack_code_in == 5'h01 && !timer0_overflow_in && !sfr_wr_in
		##1 !timer0_overflow_in && !sfr_wr_in;
	endsequence
	a_vec_idle: assert property (irq_req_out == (irq_vec_out != 5'h1f))
		else $error("request and vector disagree");
	a_gate_blocks: assert property (!en_q[7] && !$past(en_q[7]) |-> !irq_req_out)
		else $error("request with gate off");
	a_t0_raise: assert property (s_t0_ev |-> ##2 irq_req_out && irq_vec_out <= 5'h01)
		else $error("timer0 request missing");
	a_t0_ack_clr: assert property (s_t0_ack |-> ##1 irq_vec_out != 5'h01)
		else $error("timer0 flag kept after ack");
	a_run_follow: assert property (w88 |-> ##2
		timer1_run_out == $past(sfr_wdata_in[6], 2)
		&& timer0_run_out == $past(sfr_wdata_in[4], 2))
		else $error("run outputs wrong");
	a_baud_follow: assert property (w87 |-> ##2
		baud_double_out == $past(sfr_wdata_in[7], 2))
		else $error("baud output wrong");
	a_pwr_follow: assert property (wbc |-> ##2
		conv_power_out == $past(sfr_wdata_in[7], 2))
		else $error("converter power wrong");
	a_start_clear: assert property (conv_done_in |-> ##2 !conv_start_out)
		else $error("start kept after done");
endmodule // isfb_flag_bank_assertions
bind isfb_flag_bank isfb_flag_bank_assertions i_chk (.sys_clk_in, .nrst_in, .sfr_addr_in,
	.sfr_wdata_in, .sfr_wr_in, .timer0_overflow_in, .conv_done_in, .vec_ack_in,
	.vec_ack_code_in, .irq_req_out, .irq_vec_out, .timer1_run_out, .timer0_run_out,
	.baud_double_out, .conv_power_out, .conv_start_out);
`default_nettype wire

// ---- isfb_flag_bank_tb_top.sv ----
/* testbench for the flag bank: reset values, flags, pin edges, vectors.
   assumes the flag bank and the core model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module isfb_flag_bank_tb_top;
	// ====
	// stimulus and observed signals
	logic clk, nrst, wr, rd, pa, pb, ack_on, ack, req, r1, r0, baud, pwr, start;
	logic [7:0] addr, wd, rdata;
	logic [15:0] evt;
	logic [2:0] lat;
	logic [4:0] ackc, vec;
	int fails = 0;
	int n_compared = 0;
	isfb_flag_bank i_dut (.sys_clk_in(clk), .nrst_in(nrst), .sfr_addr_in(addr),
		.sfr_wdata_in(wd), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
		.timer1_overflow_in(evt[0]), .timer0_overflow_in(evt[1]),
		.uart_tx_done_in(evt[11:8]), .uart_rx_done_in(evt[15:12]),
		.frame_error_in(evt[2]), .low_supply_in(evt[3]), .power_on_event_in(evt[4]),
		.conv_done_in(evt[5]), .ext_pin_a_in(pa), .ext_pin_b_in(pb), .vec_ack_in(ack),
		.vec_ack_code_in(ackc), .irq_req_out(req), .irq_vec_out(vec), .timer1_run_out(r1),
		.timer0_run_out(r0), .baud_double_out(baud), .conv_power_out(pwr),
		.conv_start_out(start));
	isfb_core_model i_core (.sys_clk_in(clk), .nrst_in(nrst), .irq_req_in(req),
		.irq_vec_in(vec), .ack_on_in(ack_on), .lat_in(lat), .vec_ack_out(ack),
		.vec_ack_code_out(ackc));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// ====
	// shared helpers; every task returns 1 ns after a rising edge
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// the idle cycle keeps a strobe from dropping and rising in one step
	task wrr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'h1;
		tick(1);
		wr = 1'h0;
		tick(1);
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'h1;
		tick(1);
		rd = 1'h0;
		chk($sformatf("reg %h", a), e, rdata);
		tick(1);
	endtask
	task ev(input logic [15:0] m);
		evt = m;
		tick(1);
		evt = 16'h0000;
		tick(1);
	endtask
	task pin(input int k, input logic v);
		if (k) pa = v;
		else pb = v;
		tick(6);
	endtask
	// ====
	task t_reset;
		logic [7:0] ra [10];
		ra = '{8'h84, 8'h87, 8'h88, 8'h98, 8'h9a, 8'ha8, 8'hac, 8'hbc, 8'haf, 8'h80};
		for (int i = 0; i < 10; i++) begin
			rdc(ra[i], (i == 1) ? 8'h30 : 8'h00);
		end
		chk("vec", 8'h1f, {3'h0, vec});
	endtask
	task t_timer;
		wrr(8'ha8, 8'h8a);
		wrr(8'h88, 8'h50);
		chk("runs", 8'h03, {6'h00, r1, r0});
		ack_on = 1'h1;
		ev(16'h0002);
		chk("t0 vec", 8'h01, {3'h0, vec});
		tick(6);
		rdc(8'h88, 8'h50);
		lat = 3'h0;
		ev(16'h0001);
		chk("t1 vec", 8'h03, {3'h0, vec});
		tick(6);
		rdc(8'h88, 8'h50);
		ack_on = 1'h0;
		ev(16'h0003);
		chk("poll", 8'h01, {3'h0, vec});
		wrr(8'h88, 8'h50);
		chk("sw clr", 8'h00, {7'h0, req});
		wrr(8'ha8, 8'h0a);
		ev(16'h0002);
		tick(2);
		chk("gate", 8'h00, {7'h0, req});
		rdc(8'h88, 8'h70);
		wrr(8'h88, 8'h50);
		addr = 8'h88;
		wr = 1'h1;
		evt = 16'h0002;
		tick(1);
		wr = 1'h0;
		evt = 16'h0000;
		tick(1);
		rdc(8'h88, 8'h70);
		wrr(8'h88, 8'h00);
		chk("runs", 8'h00, {6'h00, r1, r0});
	endtask
	task t_ext(input int k);
		logic [7:0] fb, sb;
		fb = k ? 8'h08 : 8'h02;
		sb = k ? 8'h04 : 8'h01;
		wrr(8'h88, 8'h00);
		pin(k, 1'h0);
		rdc(8'h88, fb);
		wrr(8'h88, 8'h00);
		pin(k, 1'h1);
		rdc(8'h88, fb);
		wrr(8'h88, sb);
		pin(k, 1'h0);
		rdc(8'h88, fb | sb);
		wrr(8'h88, sb);
		pin(k, 1'h1);
		rdc(8'h88, sb);
		wrr(8'ha8, k ? 8'h84 : 8'h81);
		ack_on = 1'h1;
		pin(k, 1'h0);
		tick(8);
		rdc(8'h88, sb);
		ack_on = 1'h0;
		wrr(8'ha8, 8'h00);
	endtask
	task t_uart;
		logic [7:0] ua [4];
		logic [7:0] ux [4];
		logic [7:0] uc [4];
		ua = '{8'h98, 8'h9a, 8'hac, 8'h84};
		ux = '{8'h00, 8'h01, 8'h08, 8'h10};
		uc = '{8'h04, 8'h08, 8'h11, 8'h12};
		for (int i = 0; i < 4; i++) begin
			wrr(8'ha8, (i == 0) ? 8'h90 : 8'h80);
			wrr(8'haf, ux[i]);
			ev(16'h0100 << i);
			chk("uart vec", uc[i], {3'h0, vec});
			rdc(ua[i], 8'h02);
			ev(16'h1000 << i);
			rdc(ua[i], 8'h03);
			ack_on = 1'h1;
			tick(6);
			rdc(ua[i], 8'h03);
			ack_on = 1'h0;
			wrr(8'ha8, 8'h80);
			wrr(8'haf, 8'h00);
			chk("uart off", 8'h00, {7'h0, req});
			wrr(ua[i], 8'h00);
		end
	endtask
	task t_power;
		wrr(8'h87, 8'h00);
		rdc(8'h87, 8'h00);
		ev(16'h0008);
		rdc(8'h87, 8'h20);
		ev(16'h0010);
		rdc(8'h87, 8'h30);
		wrr(8'h87, 8'h80);
		chk("baud", 8'h01, {7'h0, baud});
		ev(16'h0004);
		rdc(8'h98, 8'h00);
		wrr(8'h87, 8'h40);
		rdc(8'h98, 8'h80);
		chk("baud", 8'h00, {7'h0, baud});
		wrr(8'ha8, 8'hc0);
		ev(16'h0008);
		chk("lowv vec", 8'h06, {3'h0, vec});
		wrr(8'h87, 8'h00);
		wrr(8'ha8, 8'h00);
	endtask
	task t_conv;
		wrr(8'hbc, 8'h88);
		chk("conv", 8'h03, {6'h00, pwr, start});
		ev(16'h0020);
		rdc(8'hbc, 8'h90);
		chk("start", 8'h00, {7'h0, start});
		wrr(8'ha8, 8'ha0);
		chk("conv vec", 8'h05, {3'h0, vec});
		wrr(8'hbc, 8'h00);
		chk("conv off", 8'h00, {6'h00, pwr, req});
	endtask
	// ====
	task stop_test;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		stop_test;
	end
	initial begin
		nrst = 1'h0;
		{wr, rd, ack_on, addr, wd, evt} = 35'h0;
		{pa, pb} = 2'h3;
		lat = 3'h1;
		repeat (16) @(posedge clk);
		#1;
		nrst = 1'h1;
		t_reset;
		t_timer;
		lat = 3'h3;
		t_ext(0);
		t_ext(1);
		t_uart;
		t_power;
		t_conv;
		stop_test;
	end
endmodule // isfb_flag_bank_tb_top
`default_nettype wire
